// File: hw/pcsia_core.sv
// program counter, circular return stack and indirect file access behind apb
//
// Chosen here: the APB slave port and the placing of the registers.
`include "pcsia_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pcsia_core
  import pcsia_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire pcsia_cmd_t  cmd,
  input  wire logic [7:0]  ind_rdata,
  output pcsia_ind_t       ind_req,
  output logic [12:0]      pc_out,
  output logic             cmd_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [`PCSIA_PC_W-1:0]        pc_reg;
  logic [`PCSIA_PC_W-1:0]        pc_next;
  logic [`PCSIA_LATCH_W-1:0]     latch_reg;
  logic [7:0]                    fptr_reg;
  logic [7:0]                    status_reg;
  logic [`PCSIA_STACK_PTR_W-1:0] sp_reg;
  logic [`PCSIA_STACK_PTR_W-1:0] sp_next;
  logic [`PCSIA_PC_W-1:0]        stack_mem [`PCSIA_STACK_DEPTH];
  logic [`PCSIA_PC_W-1:0]        push_val;
  logic                          push_en;
  logic                          pop_en;
  logic [31:0]                   prdata_reg;
  logic                          pslverr_reg;
  pcsia_ind_t                    ind_reg;
  logic                          ack_reg;
  logic                          rd_load;

  logic                          acc;
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          hit;
  logic                          pcl_wr;
  logic [`PCSIA_EA_W-1:0]        eff_addr;
  logic                          self_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so read data stands when pready rises

  assign pready    = ack_reg;
  assign cmd_ready = 1'b1;
  assign acc       = psel & penable & ack_reg;
  assign wr_acc    = acc & pwrite;
  assign rd_acc    = acc & ~pwrite;
  assign rd_load   = psel & penable & ~ack_reg & ~pwrite;
  assign prdata    = prdata_reg;
  assign pslverr   = pslverr_reg;
  assign ind_req   = ind_reg;
  assign pc_out    = pc_reg;

  always_comb begin
    unique case (paddr)
      `PCSIA_OFF_PC_LOW, `PCSIA_OFF_PC_LATCH, `PCSIA_OFF_FILE_PTR,
      `PCSIA_OFF_STATUS, `PCSIA_OFF_IND_PORT: hit = 1'b1;
      default:                                hit = 1'b0;
    endcase
  end

  assign pcl_wr   = wr_acc & (paddr == `PCSIA_OFF_PC_LOW);
  assign eff_addr = {status_reg[`PCSIA_BANK_BIT], fptr_reg};
  assign self_ptr = (fptr_reg == `PCSIA_SELF_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // next counter value; a low byte write outranks the decoder command

  always_comb begin
    pc_next  = pc_reg;
    push_en  = 1'b0;
    pop_en   = 1'b0;
    push_val = pc_reg;
    if (pcl_wr) begin
      pc_next = {latch_reg, pwdata[7:0]};
    end else begin
      unique case (cmd.op)
        PCSIA_OP_NONE: begin
          pc_next = pc_reg;
        end
        PCSIA_OP_STEP: begin
          pc_next = pc_reg + `PCSIA_PC_ONE;
        end
        PCSIA_OP_JUMP: begin
          pc_next = {latch_reg[`PCSIA_LATCH_W-1 -: 2], cmd.target};
        end
        PCSIA_OP_CALL: begin
          pc_next  = {latch_reg[`PCSIA_LATCH_W-1 -: 2], cmd.target};
          push_en  = 1'b1;
          push_val = pc_reg + `PCSIA_PC_ONE;
        end
        PCSIA_OP_RETURN: begin
          pop_en  = 1'b1;
          pc_next = stack_mem[sp_reg - `PCSIA_PTR_ONE];
        end
        PCSIA_OP_INTR: begin
          pc_next = `PCSIA_INT_VECTOR;
          push_en = 1'b1;
        end
        default: begin
          pc_next = pc_reg;
        end
      endcase
    end
  end

  // pointer wraps freely; nothing reports overflow or underflow
  always_comb begin
    sp_next = sp_reg;
    if (push_en) begin
      sp_next = sp_reg + `PCSIA_PTR_ONE;
    end else if (pop_en) begin
      sp_next = sp_reg - `PCSIA_PTR_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and stack pointer

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= `PCSIA_PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sp_reg <= `PCSIA_PTR_RST;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // stack holds no reset: contents are undefined until pushed
  generate
    for (genvar i = 0; i < `PCSIA_STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge mclk) begin
        if (push_en && (sp_reg == `PCSIA_STACK_PTR_W'(i))) begin
          stack_mem[i] <= push_val;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // software registers; the latch is touched only by its own write

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg <= `PCSIA_LATCH_RST;
    end else if (wr_acc && (paddr == `PCSIA_OFF_PC_LATCH)) begin
      latch_reg <= pwdata[`PCSIA_LATCH_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fptr_reg <= `PCSIA_BYTE_RST;
    end else if (wr_acc && (paddr == `PCSIA_OFF_FILE_PTR)) begin
      fptr_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= `PCSIA_BYTE_RST;
    end else if (wr_acc && (paddr == `PCSIA_OFF_STATUS)) begin
      status_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect port: no storage of its own, forwarded to the pointed register unless the pointer selects the port itself

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ind_reg <= '0;
    end else begin
      ind_reg.rd    <= rd_acc && (paddr == `PCSIA_OFF_IND_PORT) && !self_ptr;
      ind_reg.wr    <= wr_acc && (paddr == `PCSIA_OFF_IND_PORT) && !self_ptr;
      ind_reg.addr  <= eff_addr;
      ind_reg.wdata <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data latched at the first access edge, answered at the second

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel & penable & ~ack_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= `PCSIA_WORD_ZERO;
    end else if (rd_load) begin
      prdata_reg <= `PCSIA_WORD_ZERO;
      unique case (paddr)
        `PCSIA_OFF_PC_LOW:   prdata_reg[7:0] <= pc_reg[7:0];
        `PCSIA_OFF_PC_LATCH: prdata_reg[`PCSIA_LATCH_W-1:0] <= latch_reg;
        `PCSIA_OFF_FILE_PTR: prdata_reg[7:0] <= fptr_reg;
        `PCSIA_OFF_STATUS:   prdata_reg[7:0] <= status_reg;
        `PCSIA_OFF_IND_PORT: begin
          // far side answers from the address latched a cycle earlier
          prdata_reg[7:0] <= self_ptr ? `PCSIA_READ_SELF : ind_rdata;
        end
        default:             prdata_reg[7:0] <= `PCSIA_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_reg <= ~hit;
    end
  end

endmodule : pcsia_core

`default_nettype wire

// File: hw/pcsia_cfg.svh
// constants: register offsets, field positions, widths and reset values
`ifndef PCSIA_CFG_SVH
`define PCSIA_CFG_SVH

`define PCSIA_PC_W          13
`define PCSIA_PAGE_LSB      11
`define PCSIA_LATCH_W       5
`define PCSIA_STACK_DEPTH   8
`define PCSIA_STACK_PTR_W   3
`define PCSIA_EA_W          9
`define PCSIA_BANK_BIT      7

`define PCSIA_OFF_PC_LOW    12'h000
`define PCSIA_OFF_PC_LATCH  12'h004
`define PCSIA_OFF_FILE_PTR  12'h008
`define PCSIA_OFF_STATUS    12'h00C
`define PCSIA_OFF_IND_PORT  12'h010

`define PCSIA_PC_RST        13'h0000
`define PCSIA_LATCH_RST     5'h00
`define PCSIA_BYTE_RST      8'h00
`define PCSIA_PTR_RST       3'h0
`define PCSIA_PC_ONE        13'h0001
`define PCSIA_PTR_ONE       3'h1
`define PCSIA_SELF_ADDR     8'h00
`define PCSIA_READ_SELF     8'h00
`define PCSIA_WORD_ZERO     32'h0000_0000
`define PCSIA_INT_VECTOR    13'h0004

`endif

// File: hw/pcsia_pkg.sv
// types shared by the program counter, return stack and indirect access block
`default_nettype none
package pcsia_pkg;

  typedef enum logic [2:0] {
    PCSIA_OP_NONE,
    PCSIA_OP_STEP,
    PCSIA_OP_JUMP,
    PCSIA_OP_CALL,
    PCSIA_OP_RETURN,
    PCSIA_OP_INTR
  } pcsia_op_t;

  typedef struct packed {
    pcsia_op_t   op;
    logic [10:0] target;
  } pcsia_cmd_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pcsia_ind_t;

endpackage : pcsia_pkg

`default_nettype wire

// File: bench/pcsia_file_model.sv
// far-side data registers answering the indirect port
`timescale 1ns/1ps
`default_nettype none
module pcsia_file_model
  import pcsia_pkg::*;
(
  input  wire logic       mclk,
  input  wire pcsia_ind_t ind_req,
  output logic [7:0]      ind_rdata
);
  logic [7:0] mem [512];
  // seeded pattern so a missed write cannot read back as a match
  initial begin
    for (int k = 0; k < 512; k++) mem[k] = 8'(k) ^ 8'hA5;
  end
  always @(posedge mclk) begin
    if (ind_req.wr) mem[ind_req.addr] <= ind_req.wdata;
  end
  assign ind_rdata = mem[ind_req.addr];
endmodule : pcsia_file_model
`default_nettype wire

// File: bench/pcsia_props.sv
// assertions on counter, stack and indirect port
`timescale 1ns/1ps
`default_nettype none
module pcsia_props
  import pcsia_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire pcsia_cmd_t  cmd,
  input wire pcsia_ind_t  ind_req,
  input wire logic [12:0] pc_out
);
  // an access completes only where pready is sampled high
  wire logic acc  = psel && penable && pready;
  wire logic pclw = acc && pwrite && paddr == 12'h000;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_rst; $rose(reset_n) |-> pc_out == 13'h0000; endproperty
  a_rst: assert property (p_rst)
    else $error("pc not clear after reset");
  property p_step; cmd.op == PCSIA_OP_STEP && !pclw |=> pc_out == $past(pc_out) + 13'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("step wrong");
  property p_br; (cmd.op == PCSIA_OP_JUMP || cmd.op == PCSIA_OP_CALL) && !pclw
    |=> pc_out[10:0] == $past(cmd.target); endproperty
  a_br: assert property (p_br)
    else $error("branch target wrong");
  property p_pclw; pclw |=> pc_out[7:0] == $past(pwdata[7:0]); endproperty
  a_pclw: assert property (p_pclw)
    else $error("low byte write lost");
  property p_intr; cmd.op == PCSIA_OP_INTR && !pclw |=> pc_out == 13'h0004; endproperty
  a_intr: assert property (p_intr)
    else $error("vector wrong");
  property p_ret; cmd.op == PCSIA_OP_CALL && !pclw ##1 cmd.op == PCSIA_OP_RETURN && !pclw
    |=> pc_out == $past(pc_out, 2) + 13'h0001; endproperty
  a_ret: assert property (p_ret)
    else $error("return address wrong");
  property p_rd; acc && !pwrite && paddr == 12'h000
    |-> prdata == {24'h0, $past(pc_out[7:0])}; endproperty
  a_rd: assert property (p_rd)
    else $error("low byte read wrong");
  property p_self; ind_req.wr |-> ind_req.addr[7:0] != 8'h00; endproperty
  a_self: assert property (p_self)
    else $error("self write stored");
  property p_indw; acc && pwrite && paddr == 12'h010 |=> ind_req.addr[7:0] == 8'h00
    || (ind_req.wr && ind_req.wdata == $past(pwdata[7:0])); endproperty
  a_indw: assert property (p_indw)
    else $error("indirect write lost");
endmodule : pcsia_props
bind pcsia_core pcsia_props u_props (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .cmd, .ind_req, .pc_out);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for counter, stack and indirect port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pcsia_pkg::*;
;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, cmd_ready, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pcsia_cmd_t  cmd;
  pcsia_ind_t  ind_req;
  logic [7:0]  ind_rdata;
  logic [12:0] pc_out;
  integer      err_total, n_tests, seed, pc, lat, sp, i, v;
  integer      stk [8];
  pcsia_core dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cmd, .ind_rdata, .ind_req, .pc_out, .cmd_ready);
  pcsia_file_model far (.mclk, .ind_req, .ind_rdata);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input integer d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    // answer taken at the edge where pready is sampled high
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic go(input pcsia_op_t o, input integer t);
    cmd.op <= o;
    cmd.target <= t[10:0];
    @(posedge mclk);
    if (o == PCSIA_OP_CALL || o == PCSIA_OP_INTR) begin
      stk[sp] = (o == PCSIA_OP_CALL) ? (pc + 1) % 8192 : pc;
      sp = (sp + 1) % 8;
    end
    if (o == PCSIA_OP_RETURN) begin
      sp = (sp + 7) % 8;
      pc = stk[sp];
    end
    if (o == PCSIA_OP_STEP) pc = (pc + 1) % 8192;
    if (o == PCSIA_OP_INTR) pc = 4;
    if (o == PCSIA_OP_JUMP || o == PCSIA_OP_CALL) pc = (lat / 8 % 4) * 2048 + t;
    #1 chk("pc_out", {19'h0, pc_out}, pc);
  endtask : go
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up;
  end
  initial begin
    {err_total, n_tests, sp, pc, lat} = '0;
    seed = 32'hd5317c61;
    {reset_n, psel, penable, pwrite, paddr, pwdata, cmd} = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    #1 chk("pc_rst", {19'h0, pc_out}, 0);
    // ten calls overrun the eight entries before unwinding
    for (i = 0; i < 10; i++) go(PCSIA_OP_CALL, i * 100 + 5);
    for (i = 0; i < 10; i++) go(PCSIA_OP_RETURN, 0);
    for (i = 0; i < 300; i++) begin
      if (i % 20 == 0) begin
        go(PCSIA_OP_NONE, 0);
        v = $random(seed);
        apb(1'b1, 12'h004, v);
        lat = v & 31;
        apb(1'b1, 12'h000, v >> 8);
        pc = lat * 256 + (v >> 8 & 255);
        #1 chk("pc_wr", {19'h0, pc_out}, pc);
        apb(1'b0, 12'h000, 0);
        chk("pc_rd", rd, pc & 255);
      end
      go(pcsia_op_t'(($random(seed) & 32'h7FFF) % 6), $random(seed) & 2047);
    end
    // mid-run reset: counter and pointer clear, stack contents survive
    go(PCSIA_OP_NONE, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    {pc, sp, lat} = '0;
    #1 chk("pc_rst2", {19'h0, pc_out}, pc);
    chk("cmd_ready", {31'h0, cmd_ready}, 1);
    go(PCSIA_OP_NONE, 0);
    for (i = 0; i < 4; i++) begin
      v = ($random(seed) & 255) | 1;
      apb(1'b1, 12'h008, v);
      apb(1'b1, 12'h00C, 32'h80);
      apb(1'b1, 12'h010, v ^ 8'h3C);
      apb(1'b0, 12'h010, 0);
      chk("ind_bank1", rd, v ^ 8'h3C);
      apb(1'b1, 12'h00C, 0);
      apb(1'b0, 12'h010, 0);
      chk("ind_bank0", rd, v ^ 8'hA5);
    end
    apb(1'b1, 12'h008, 0);
    apb(1'b1, 12'h010, 8'h77);
    apb(1'b0, 12'h010, 0);
    chk("ind_self", rd, 0);
    chk("self_nowrite", {24'h0, far.mem[0]}, 8'hA5);
    chk("pslverr_mapped", {31'h0, perr}, 0);
    apb(1'b0, 12'h020, 0);
    chk("unmapped", rd, 0);
    chk("pslverr_unmapped", {31'h0, perr}, 1);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
